// ===== hdl/ssid_nvm.sv
// Purpose: Nonvolatile word store with timed programming
// Assumes: Requests arriving while busy are dropped by the requester
// Notes:   Contents return to factory values only on power-up reset
`timescale 1ns/100ps
`default_nettype none
module ssid_nvm #(
  parameter int unsigned                  WORDS    = ssid_pkg::NVM_WORDS,
  parameter int unsigned                  PROG_CYC = 175000,
  parameter logic [WORDS-1:0][15:0]       FACTORY  = '0
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire ssid_pkg::ssid_nvm_req_t    req,
  output logic                            busy,
  output logic [WORDS-1:0][15:0]          words
);

  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;
    logic                   busy;
    logic [31:0]            cnt;
    logic [1:0]             slot;
    logic [15:0]            data;
  } ssid_nvm_st_t;

  ssid_nvm_st_t q;
  ssid_nvm_st_t d;

  always_comb begin
    d = q;
    if (q.busy) begin
      if (q.cnt == 32'(PROG_CYC - 1)) begin
        if (32'(q.slot) < 32'(WORDS)) begin
          d.mem[q.slot] = q.data;
        end
        d.busy = 1'b0;
      end else begin
        d.cnt = q.cnt + 32'h1;
      end
    end else if (req.valid) begin
      d.busy = 1'b1;
      d.cnt  = 32'h0;
      d.slot = req.slot;
      d.data = req.data;
    end
    if (reset) begin
      d     = '0;
      d.mem = FACTORY;
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign busy  = q.busy;
  assign words = q.mem;

endmodule : ssid_nvm
`default_nettype wire

// ===== hdl/ssid_regs.sv
// Purpose: Two-wire bus target with scratch, limit and ID registers
// Assumes: SCL/SDA/address straps are asynchronous pins
// Notes:   Temperature value comes from an external converter on ref_clk
//
// Summary of operation
// R1 - Scratch word at 07h, sixteen bits read/write, resets to zero.
// R2 - Second scratch word at 08h, reset value device dependent.
// R3 - Both scratch words follow the same lock-dependent write handling.
// R4 - Locked writes update logic only; unlocked writes also program storage.
// R5 - Read-only sixteen-bit part code at 0Fh.
// R6 - Bus target only: clock input, data bidirectional, alert output.
// R7 - Two strap pins pick one of four bus addresses.
// R8 - Alert flags limit crossing or conversion end for host interrupt.
// R9 - Averaging of 8, 32 or 64 samples, or none.
// R10 - 8-sample conversion is 125 ms active, rest of cycle standby.
// R11 - General-call reset reloads in 1.5 ms, then all sample together.
// R12 - Host reads each result within the 16 s cycle.
// R13 - High limit at 02h reloads from storage after any reset.
// R14 - Scratch words reload from storage after any reset.
`timescale 1ns/100ps
`default_nettype none
module ssid_regs #(
  parameter logic [6:0]  ADDR_BASE    = 7'h40,
  parameter logic [15:0] PART_CODE    = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] SCR4_FACTORY = 16'h0000,
  parameter int unsigned RESET_CYC    = ssid_pkg::RESET_US * ssid_pkg::CLK_MHZ,
  parameter int unsigned ACT0_CYC     = ssid_pkg::ACT_NONE_US*ssid_pkg::CLK_MHZ,
  parameter int unsigned ACT8_CYC     = ssid_pkg::ACT_8_US * ssid_pkg::CLK_MHZ,
  parameter int unsigned ACT32_CYC    = ssid_pkg::ACT_32_US * ssid_pkg::CLK_MHZ,
  parameter int unsigned ACT64_CYC    = ssid_pkg::ACT_64_US * ssid_pkg::CLK_MHZ,
  parameter int unsigned CYC_LONG     = ssid_pkg::CYC_LONG_US*ssid_pkg::CLK_MHZ,
  parameter int unsigned NVM_PROG_CYC = ssid_pkg::NVM_PROG_US*ssid_pkg::CLK_MHZ
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             alert_o,
  output logic             alert_oe,
  input  wire logic [1:0]  addr_sel,
  input  wire logic [15:0] temp_sample,
  output logic             conv_active
);

  typedef struct packed {
    logic                    scl_s1, scl_s2, scl_s3;
    logic                    sda_s1, sda_s2, sda_s3;
    logic [1:0]              asel_s1, asel_s2;
    ssid_pkg::ssid_bus_st_t  bus;
    ssid_pkg::ssid_role_t    role;
    logic [3:0]              bit_cnt;
    logic [7:0]              sh;
    logic                    rw;
    logic [7:0]              ptr;
    logic                    lo_next;
    logic [7:0]              wbuf;
    logic [15:0]             tx;
    logic                    tx_lo;
    logic                    sda_oe;
    logic                    sda_o;
    logic [15:0]             temp;
    logic [15:0]             cfg;
    logic [15:0]             high;
    logic                    unlock;
    logic [15:0]             scr3;
    logic [15:0]             scr4;
    logic                    rld;
    logic [31:0]             rcnt;
    ssid_pkg::ssid_conv_st_t conv;
    logic [31:0]             ccnt;
    logic                    drdy;
    logic                    act;
    logic                    alert_oe;
    logic                    alert_o;
    ssid_pkg::ssid_nvm_req_t nvm_req;
  } ssid_st_t;

  ssid_st_t                                q;
  ssid_st_t                                d;
  logic                                    nvm_busy;
  logic [ssid_pkg::NVM_WORDS-1:0][15:0]    nvm_words;
  logic                                    scl_rise, scl_fall, bus_start;
  logic                                    bus_stop;
  logic [15:0]                             wdata;
  logic [15:0]                             rd_word;
  logic [31:0]                             act_cyc;
  logic [31:0]                             period;

  ssid_nvm #(
    .WORDS    (ssid_pkg::NVM_WORDS),
    .PROG_CYC (NVM_PROG_CYC),
    .FACTORY  ({SCR4_FACTORY, ssid_pkg::SCR3_RST, ssid_pkg::HIGH_RST})
  ) u_nvm (
    .ref_clk (ref_clk),
    .reset   (reset),
    .req     (q.nvm_req),
    .busy    (nvm_busy),
    .words   (nvm_words)
  );

  function automatic logic [15:0] read_mux(input ssid_st_t s,
                                           input logic     busy);
    case (s.ptr)
      ssid_pkg::PTR_TEMP:   read_mux = s.temp;
      ssid_pkg::PTR_CFG:    read_mux = s.cfg;
      ssid_pkg::PTR_HIGH:   read_mux = s.high;
      ssid_pkg::PTR_UNLOCK: read_mux = {s.unlock, busy, 14'h0000};
      ssid_pkg::PTR_SCR3:   read_mux = s.scr3; // see R1
      ssid_pkg::PTR_SCR4:   read_mux = s.scr4; // see R2
      ssid_pkg::PTR_PART:   read_mux = PART_CODE; // see R5
      default:              read_mux = 16'h0000;
    endcase
  endfunction : read_mux

  function automatic logic [31:0] act_cycles(input logic [1:0] avg);
    case (avg)
      ssid_pkg::AVG_NONE: act_cycles = 32'(ACT0_CYC);
      ssid_pkg::AVG_8:    act_cycles = 32'(ACT8_CYC); // see R10
      ssid_pkg::AVG_32:   act_cycles = 32'(ACT32_CYC);
      default:            act_cycles = 32'(ACT64_CYC);
    endcase
  endfunction : act_cycles

  assign scl_rise  = q.scl_s2 & ~q.scl_s3;
  assign scl_fall  = ~q.scl_s2 & q.scl_s3;
  assign bus_start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign bus_stop  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign wdata     = {q.wbuf, q.sh};
  assign rd_word   = read_mux(q, nvm_busy);
  assign act_cyc   = act_cycles(q.cfg[ssid_pkg::CFG_AVG_LSB +: 2]); // see R9
  assign period    = q.cfg[ssid_pkg::CFG_CYC_BIT] ? 32'(CYC_LONG) : act_cyc;

  always_comb begin
    d = q;
    // Pin synchronisers, see R6
    d.scl_s1  = scl_i;
    d.scl_s2  = q.scl_s1;
    d.scl_s3  = q.scl_s2;
    d.sda_s1  = sda_i;
    d.sda_s2  = q.sda_s1;
    d.sda_s3  = q.sda_s2;
    d.asel_s1 = addr_sel;
    d.asel_s2 = q.asel_s1;
    d.nvm_req.valid = 1'b0;

    if (bus_start) begin
      d.bus     = ssid_pkg::BUS_RX;
      d.role    = ssid_pkg::ROLE_ADDR;
      d.bit_cnt = 4'h0;
      d.sda_oe  = 1'b0;
    end else if (bus_stop) begin
      d.bus    = ssid_pkg::BUS_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.bus)
        ssid_pkg::BUS_RX: begin
          d.sh      = {q.sh[6:0], q.sda_s2};
          d.bit_cnt = q.bit_cnt + 4'h1;
        end
        ssid_pkg::BUS_TX_ACK: begin
          if (q.sda_s2) begin
            d.bus = ssid_pkg::BUS_IDLE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (q.bus)
        ssid_pkg::BUS_RX: begin
          if (q.bit_cnt == 4'h8) begin
            d.bus     = ssid_pkg::BUS_RX_ACK;
            d.sda_oe  = 1'b1;
            d.bit_cnt = 4'h0;
            case (q.role)
              ssid_pkg::ROLE_ADDR: begin
                d.rw = q.sh[0];
                if (q.sh[7:1] == {ADDR_BASE[6:2], q.asel_s2}) begin
                  d.role = ssid_pkg::ROLE_ADDR; // see R7
                end else if (q.sh == ssid_pkg::GC_ADDR) begin
                  d.role = ssid_pkg::ROLE_GC;
                end else begin
                  d.bus    = ssid_pkg::BUS_IDLE;
                  d.sda_oe = 1'b0;
                end
              end
              ssid_pkg::ROLE_PTR: begin
                d.ptr     = q.sh;
                d.lo_next = 1'b0;
                d.role    = ssid_pkg::ROLE_DATA;
              end
              ssid_pkg::ROLE_DATA: begin
                d.lo_next = ~q.lo_next;
                if (!q.lo_next) begin
                  d.wbuf = q.sh;
                end else begin
                  case (q.ptr)
                    ssid_pkg::PTR_CFG:
                      d.cfg = wdata & ssid_pkg::CFG_WR_MASK;
                    ssid_pkg::PTR_HIGH: d.high = wdata;
                    ssid_pkg::PTR_UNLOCK:
                      d.unlock = wdata[ssid_pkg::UNLOCK_BIT];
                    ssid_pkg::PTR_SCR3: d.scr3 = wdata; // see R1
                    ssid_pkg::PTR_SCR4: d.scr4 = wdata; // see R2
                    default: ;
                  endcase
                  // Unlocked writes also program the backing word
                  if (q.unlock && !nvm_busy) begin // see R3
                    d.nvm_req.data = wdata;
                    case (q.ptr)
                      ssid_pkg::PTR_HIGH: begin
                        d.nvm_req.valid = 1'b1; // see R4
                        d.nvm_req.slot  = ssid_pkg::NVM_SLOT_HIGH;
                      end
                      ssid_pkg::PTR_SCR3: begin
                        d.nvm_req.valid = 1'b1; // see R4
                        d.nvm_req.slot  = ssid_pkg::NVM_SLOT_SCR3;
                      end
                      ssid_pkg::PTR_SCR4: begin
                        d.nvm_req.valid = 1'b1; // see R4
                        d.nvm_req.slot  = ssid_pkg::NVM_SLOT_SCR4;
                      end
                      default: ;
                    endcase
                  end
                end
              end
              ssid_pkg::ROLE_GC: begin
                if (q.sh == ssid_pkg::GC_RESET_CMD) begin
                  d.role = ssid_pkg::ROLE_END;
                  d.rld  = 1'b1; // see R11
                  d.rcnt = 32'h0;
                end else begin
                  d.bus    = ssid_pkg::BUS_IDLE;
                  d.sda_oe = 1'b0;
                end
              end
              default: begin
                d.bus    = ssid_pkg::BUS_IDLE;
                d.sda_oe = 1'b0;
              end
            endcase
          end
        end
        ssid_pkg::BUS_RX_ACK: begin
          d.sda_oe  = 1'b0;
          d.bit_cnt = 4'h0;
          d.bus     = ssid_pkg::BUS_RX;
          if (q.role == ssid_pkg::ROLE_ADDR && q.rw) begin
            d.tx      = {rd_word[14:0], 1'b0};
            d.sda_oe  = ~rd_word[15];
            d.tx_lo   = 1'b0;
            d.bit_cnt = 4'h1;
            d.bus     = ssid_pkg::BUS_TX;
            if (q.ptr == ssid_pkg::PTR_TEMP) begin
              d.drdy = 1'b0;
            end
          end else if (q.role == ssid_pkg::ROLE_ADDR) begin
            d.role = ssid_pkg::ROLE_PTR;
          end else if (q.role == ssid_pkg::ROLE_END) begin
            d.bus = ssid_pkg::BUS_IDLE;
          end
        end
        ssid_pkg::BUS_TX: begin
          if (q.bit_cnt == 4'h8) begin
            d.sda_oe = 1'b0;
            d.bus    = ssid_pkg::BUS_TX_ACK;
          end else begin
            d.sda_oe  = ~q.tx[15];
            d.tx      = {q.tx[14:0], 1'b0};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
        end
        ssid_pkg::BUS_TX_ACK: begin
          d.bus     = ssid_pkg::BUS_TX;
          d.bit_cnt = 4'h1;
          d.tx_lo   = ~q.tx_lo;
          if (!q.tx_lo) begin
            d.sda_oe = ~q.tx[15];
            d.tx     = {q.tx[14:0], 1'b0};
          end else begin
            d.tx     = {rd_word[14:0], 1'b0};
            d.sda_oe = ~rd_word[15];
            if (q.ptr == ssid_pkg::PTR_TEMP) begin
              d.drdy = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    // Conversion sequencing; set of the ready flag wins over its clear
    if (q.rld) begin
      d.high   = nvm_words[ssid_pkg::NVM_SLOT_HIGH]; // see R13
      d.scr3   = nvm_words[ssid_pkg::NVM_SLOT_SCR3]; // see R14
      d.scr4   = nvm_words[ssid_pkg::NVM_SLOT_SCR4]; // see R14
      d.cfg    = ssid_pkg::CFG_RST;
      d.unlock = 1'b0;
      d.drdy   = 1'b0;
      d.conv   = ssid_pkg::CONV_IDLE;
      d.rcnt   = q.rcnt + 32'h1;
      if (q.rcnt == 32'(RESET_CYC - 1)) begin
        d.rld  = 1'b0;
        d.conv = ssid_pkg::CONV_RUN; // see R11
        d.ccnt = 32'h0;
      end
    end else if (q.conv == ssid_pkg::CONV_RUN) begin
      d.ccnt = q.ccnt + 32'h1;
      if (q.ccnt == act_cyc - 32'h1) begin
        d.temp = temp_sample;
        d.drdy = 1'b1; // see R8
      end
      if (q.ccnt >= act_cyc - 32'h1 && q.ccnt >= period - 32'h1) begin
        d.ccnt = 32'h0; // see R10
        if (!q.cfg[ssid_pkg::CFG_CC_BIT]) begin
          d.conv = ssid_pkg::CONV_IDLE;
        end
      end
    end else if (q.cfg[ssid_pkg::CFG_CC_BIT]) begin
      d.conv = ssid_pkg::CONV_RUN;
      d.ccnt = 32'h0;
    end

    // Active phase only; standby of a long cycle shows low
    d.act = (d.conv == ssid_pkg::CONV_RUN) && (d.ccnt < act_cyc); // see R10

    // Open-drain alert, pulled low while active
    d.alert_o  = 1'b0;
    d.alert_oe = q.cfg[ssid_pkg::CFG_ASEL_BIT] ? q.drdy :
                 ($signed(q.temp) > $signed(q.high)); // see R8
    d.sda_o    = 1'b0;

    if (reset) begin
      d        = '0;
      d.bus    = ssid_pkg::BUS_IDLE;
      d.role   = ssid_pkg::ROLE_ADDR;
      d.conv   = ssid_pkg::CONV_IDLE;
      d.scl_s1 = 1'b1;
      d.scl_s2 = 1'b1;
      d.scl_s3 = 1'b1;
      d.sda_s1 = 1'b1;
      d.sda_s2 = 1'b1;
      d.sda_s3 = 1'b1;
      d.temp   = ssid_pkg::TEMP_RST;
      d.cfg    = ssid_pkg::CFG_RST;
      d.high   = ssid_pkg::HIGH_RST;
      d.scr3   = ssid_pkg::SCR3_RST;
      d.scr4   = SCR4_FACTORY;
      d.rld    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign sda_o       = q.sda_o;
  assign sda_oe      = q.sda_oe;
  assign alert_o     = q.alert_o;
  assign alert_oe    = q.alert_oe;
  assign conv_active = q.act;

endmodule : ssid_regs
`default_nettype wire

// ===== include/ssid_pkg.sv
// Purpose: Shared constants and types for the sensor scratch/ID register bank
// Assumes: 25 MHz ref_clk; times are given in microseconds
// Notes:   Pointer values are the bus register pointers
package ssid_pkg;

  localparam int unsigned CLK_MHZ = 25;

  // Register pointers
  localparam logic [7:0] PTR_TEMP   = 8'h00;
  localparam logic [7:0] PTR_CFG    = 8'h01;
  localparam logic [7:0] PTR_HIGH   = 8'h02;
  localparam logic [7:0] PTR_UNLOCK = 8'h04;
  localparam logic [7:0] PTR_SCR3   = 8'h07;
  localparam logic [7:0] PTR_SCR4   = 8'h08;
  localparam logic [7:0] PTR_PART   = 8'h0f;

  // Field positions
  localparam int unsigned UNLOCK_BIT    = 15;
  localparam int unsigned BUSY_BIT      = 14;
  localparam int unsigned CFG_CC_BIT    = 10;
  localparam int unsigned CFG_CYC_BIT   = 7;
  localparam int unsigned CFG_AVG_LSB   = 5;
  localparam int unsigned CFG_ASEL_BIT  = 2;
  localparam logic [15:0] CFG_WR_MASK   = 16'h04e4;

  // Reset values
  localparam logic [15:0] TEMP_RST = 16'h0000;
  localparam logic [15:0] CFG_RST  = 16'h0420;
  localparam logic [15:0] HIGH_RST = 16'h6000;
  localparam logic [15:0] SCR3_RST = 16'h0000;

  // Averaging codes
  localparam logic [1:0] AVG_NONE = 2'h0;
  localparam logic [1:0] AVG_8    = 2'h1;
  localparam logic [1:0] AVG_32   = 2'h2;
  localparam logic [1:0] AVG_64   = 2'h3;

  // Bus constants
  localparam logic [7:0] GC_ADDR      = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;

  // Times in microseconds
  localparam int unsigned RESET_US     = 1500;
  localparam int unsigned ACT_NONE_US  = 15500;
  localparam int unsigned ACT_8_US     = 125000;
  localparam int unsigned ACT_32_US    = 500000;
  localparam int unsigned ACT_64_US    = 1000000;
  localparam int unsigned CYC_LONG_US  = 16000000;
  localparam int unsigned NVM_PROG_US  = 7000;

  // Nonvolatile slots
  localparam int unsigned NVM_WORDS     = 3;
  localparam logic [1:0]  NVM_SLOT_HIGH = 2'h0;
  localparam logic [1:0]  NVM_SLOT_SCR3 = 2'h1;
  localparam logic [1:0]  NVM_SLOT_SCR4 = 2'h2;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_RX, BUS_RX_ACK, BUS_TX, BUS_TX_ACK
  } ssid_bus_st_t;

  typedef enum logic [2:0] {
    ROLE_ADDR, ROLE_PTR, ROLE_DATA, ROLE_GC, ROLE_END
  } ssid_role_t;

  typedef enum logic [1:0] {
    CONV_IDLE, CONV_RUN
  } ssid_conv_st_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  slot;
    logic [15:0] data;
  } ssid_nvm_req_t;

endpackage : ssid_pkg

// ===== test/ssid_host.sv
// Purpose: Behavioural two-wire bus controller facing the sensor
// Assumes: Open-drain data line resolved in the bench with a pull-up
// Notes:   H sets each bus clock phase in ref_clk cycles
`timescale 1ns/100ps
`default_nettype none
module ssid_host #(
  parameter int H = 8
) (
  input  wire logic ref_clk,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low
);
  initial begin
    scl_o   = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : hold

  task automatic start();
    sda_low = 1'b0;
    hold(H);
    scl_o = 1'b1;
    hold(H);
    sda_low = 1'b1;
    hold(H);
    scl_o = 1'b0;
    hold(2);
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    hold(H);
    scl_o = 1'b1;
    hold(H);
    sda_low = 1'b0;
    hold(H);
  endtask : stop

  // Controller owns the bus clock; target only answers
  task automatic clk_bit(input logic b, output logic r);
    sda_low = !b;
    hold(H);
    scl_o = 1'b1;
    hold(H / 2);
    r = sda_i;
    hold(H / 2);
    scl_o = 1'b0;
    hold(2);
  endtask : clk_bit

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(ack_in, ack_out);
  endtask : xfer

  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [15:0] val, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    xfer(val[15:8], 1'b1, rx, a2);
    xfer(val[7:0], 1'b1, rx, a3);
    stop();
    ok = !(a0 || a1 || a2 || a3);
  endtask : wr_reg

  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ptr,
                        output logic [15:0] val, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, n0, n1;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    start();
    xfer({dev, 1'b1}, 1'b1, rx, a2);
    xfer(8'hff, 1'b0, val[15:8], n0);
    xfer(8'hff, 1'b1, val[7:0], n1);
    stop();
    ok = !(a0 || a1 || a2);
  endtask : rd_reg

  task automatic gc_reset(output logic ok);
    logic [7:0] rx;
    logic       a0, a1;
    start();
    xfer(8'h00, 1'b1, rx, a0);
    xfer(8'h06, 1'b1, rx, a1);
    stop();
    ok = !(a0 || a1);
  endtask : gc_reset
endmodule : ssid_host
`default_nettype wire

// ===== test/ssid_regs_bench.sv
// Purpose: Self-checking bench for the scratch/ID register bank
// Assumes: Shortened reload, conversion and programming counts
// Notes:   Expected register contents kept in an associative model
`timescale 1ns/100ps
`default_nettype none
module ssid_regs_bench;
  localparam int          RST_CYC = 20;
  localparam int          CLONG   = 400;
  localparam int          ACT[4]  = '{50, 80, 120, 160};
  localparam logic [15:0] PART    = 16'h3c96; // Arbitrary value
  localparam logic [15:0] SCR4F   = 16'h2b71; // Arbitrary value

  logic        ref_clk     = 1'b0;
  logic        reset       = 1'b1;
  logic [1:0]  addr_sel    = 2'h0;
  logic [15:0] temp_sample = 16'h0000;
  logic        scl, host_low, sda_o, sda_oe, alert_o, alert_oe, conv_active;
  wire logic   sda_bus = !(host_low || (sda_oe && !sda_o));
  int          bad_count  = 0;
  int          num_checks = 0;
  int          exp_reg [int];
  logic [6:0]  dev = 7'h40;

  always #20 ref_clk = ~ref_clk;

  ssid_host u_host (.ref_clk(ref_clk), .sda_i(sda_bus), .scl_o(scl),
                    .sda_low(host_low));
  ssid_regs #(
    .PART_CODE(PART), .SCR4_FACTORY(SCR4F), .RESET_CYC(RST_CYC),
    .ACT0_CYC(ACT[0]), .ACT8_CYC(ACT[1]), .ACT32_CYC(ACT[2]),
    .ACT64_CYC(ACT[3]), .CYC_LONG(CLONG), .NVM_PROG_CYC(10)
  ) u_dut (
    .ref_clk(ref_clk), .reset(reset), .scl_i(scl), .sda_i(sda_bus),
    .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe),
    .addr_sel(addr_sel), .temp_sample(temp_sample),
    .conv_active(conv_active)
  );

  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic compare(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask : compare

  task automatic rd_chk(input logic [7:0] ptr);
    logic [15:0] v;
    logic        ok;
    u_host.rd_reg(dev, ptr, v, ok);
    compare(16'(ok), 16'h0001, "read ack");
    compare(v, 16'(exp_reg[ptr]), "read data");
  endtask : rd_chk

  // Read-only and unmapped places keep their model value
  task automatic wr(input logic [7:0] ptr, input logic [15:0] val);
    logic ok;
    u_host.wr_reg(dev, ptr, val, ok);
    compare(16'(ok), 16'h0001, "write ack");
    if (ptr inside {8'h02, 8'h07, 8'h08}) exp_reg[ptr] = val;
  endtask : wr

  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (conv_active !== lvl && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_lvl

  initial begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    close_out();
  end

  initial begin
    logic [15:0] v;
    logic [15:0] x;
    logic        ok;
    int          n;
    int          hi;
    int          lo;
    void'($urandom(53499));
    exp_reg[8'h02] = 16'h6000;
    exp_reg[8'h07] = 16'h0000;
    exp_reg[8'h08] = SCR4F;
    exp_reg[8'h0f] = PART;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    repeat (RST_CYC + 10) @(negedge ref_clk);
    rd_chk(8'h07);
    rd_chk(8'h08);
    rd_chk(8'h0f);
    rd_chk(8'h02);
    for (int s = 0; s < 4; s++) begin
      addr_sel = 2'(s);
      dev = 7'(64 + s);
      repeat (8) @(negedge ref_clk);
      u_host.wr_reg(7'(64 + (s + 1) % 4), 8'h07, 16'hffff, ok);
      compare(16'(ok), 16'h0000, "foreign address ack");
      wr(8'h07, 16'($urandom));
      wr(8'h08, 16'($urandom));
      wr(8'h0f, 16'($urandom));
      rd_chk(8'h07);
      rd_chk(8'h08);
      rd_chk(8'h0f);
    end
    x = 16'($urandom);
    wr(8'h04, 16'h8000);
    wr(8'h07, x);
    wr(8'h04, 16'h0000);
    wr(8'h07, ~x);
    wr(8'h02, 16'($urandom));
    rd_chk(8'h07);
    u_host.gc_reset(ok);
    compare(16'(ok), 16'h0001, "general call ack");
    repeat (RST_CYC + 10) @(negedge ref_clk);
    exp_reg[8'h07] = x;
    exp_reg[8'h08] = SCR4F;
    exp_reg[8'h02] = 16'h6000;
    rd_chk(8'h07);
    rd_chk(8'h08);
    rd_chk(8'h02);
    for (int a = 0; a < 4; a++) begin
      wr(8'h01, 16'h0480 | 16'(a << 5));
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
      compare(16'(hi), 16'(ACT[a]), "active time");
      compare(16'(hi + lo), 16'(CLONG), "cycle time");
    end
    for (int k = 0; k < 3; k++) begin
      v = 16'($urandom);
      temp_sample = (k == 1) ? ((v & 16'h1fff) | 16'h6001) :
                    (v & ((k == 0) ? 16'hffff : 16'h3fff));
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      repeat (3) @(negedge ref_clk);
      compare(16'(alert_oe), 16'($signed(temp_sample) > 24576), "alert");
    end
    // Data-ready alert mode; last sample is below the limit
    wr(8'h01, 16'h0484);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    repeat (3) @(negedge ref_clk);
    compare(16'(alert_oe), 16'h0001, "ready alert");
    close_out();
  end
endmodule : ssid_regs_bench

bind ssid_regs ssid_regs_monitor #(.CYC_LONG(CYC_LONG)) u_mon (
  .ref_clk(ref_clk), .reset(reset), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe),
  .addr_sel(addr_sel), .temp_sample(temp_sample), .conv_active(conv_active)
);
`default_nettype wire

// ===== test/ssid_regs_monitor.sv
// Purpose: Port-level checks for the scratch/ID register bank
// Assumes: Bench-sized cycle count handed in by bind; continuous mode
// Notes:   Sees only the pins of ssid_regs
`timescale 1ns/100ps
`default_nettype none
module ssid_regs_monitor #(
  parameter int unsigned CYC_LONG = 400
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        alert_o,
  input wire logic        alert_oe,
  input wire logic [1:0]  addr_sel,
  input wire logic [15:0] temp_sample,
  input wire logic        conv_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic [31:0] low_q;
  logic [31:0] low_d;

  // Length of the current standby gap
  always_comb low_d = conv_active ? 32'h0 : low_q + 32'h1;
  always_ff @(posedge ref_clk) low_q <= reset ? 32'h0 : low_d;

  data_drive_low_a: assert property (sda_oe |-> !sda_o)
    else $error("data pin driven high");
  alert_drive_low_a: assert property (alert_oe |-> !alert_o)
    else $error("alert pin driven high");
  sda_scl_low_a: assert property (
    $changed(sda_oe) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2))
    else $error("data pin moved while bus clock high");
  sda_bit_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("data pin bit too short");
  conv_reload_a: assert property ($fell(reset) |-> !conv_active [*8])
    else $error("conversion during reload");
  conv_start_a: assert property ($fell(reset) |-> ##[1:60] conv_active)
    else $error("conversion did not start after reload");
  standby_bound_a: assert property (
    !conv_active |-> low_q < CYC_LONG)
    else $error("standby gap too long");
  alert_reload_a: assert property ($fell(reset) |-> !alert_oe [*8])
    else $error("alert during reload");
  sda_idle_a: assert property ($fell(reset) |-> !sda_oe [*8])
    else $error("data pin driven after reset");

  cover property ($rose(sda_oe));
  cover property ($rose(alert_oe));
  cover property ($fell(conv_active));
endmodule : ssid_regs_monitor
`default_nettype wire
